// ---- hw/gdfe_pkg.sv ----
// Purpose: Shared constants for the gate driver fault and enable logic
// Assumes: 125 MHz core clock, all analog levels already digitized
// Notes:   Register map is a small Avalon-MM word map
package gdfe_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned DEGLITCH_NS     = 40;
  localparam int unsigned DEGLITCH_CYC    = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MON_FREQ_KHZ    = 400;
  localparam int unsigned MON_PERIOD_CYC  = 1000000 / (MON_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int unsigned MON_DUTY_MIN_PC = 5;
  localparam int unsigned MON_DUTY_MAX_PC = 95;
  localparam int unsigned PCT_FULL        = 100;

  // Widths
  localparam int unsigned CNT_W   = 20;
  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned MON_W   = 9;

  typedef logic [CNT_W-1:0]   gdfe_cnt_t;
  typedef logic [LEVEL_W-1:0] gdfe_level_t;
  typedef logic [ADDR_W-1:0]  gdfe_addr_t;
  typedef logic [DATA_W-1:0]  gdfe_data_t;

  // Register byte offsets
  localparam gdfe_addr_t REG_STATUS   = 4'h0;
  localparam gdfe_addr_t REG_MUTE_CYC = 4'h4;
  localparam gdfe_addr_t REG_FILT_CYC = 4'h8;
  localparam gdfe_addr_t REG_SHDN_CYC = 4'hc;

  // Status bit positions
  localparam int unsigned ST_FAULT    = 0;
  localparam int unsigned ST_ENABLED  = 1;
  localparam int unsigned ST_PGOOD    = 2;
  localparam int unsigned ST_MUTE     = 3;
  localparam int unsigned ST_GATE     = 4;
  localparam int unsigned ST_SOFT_OFF = 5;
  localparam int unsigned ST_FORCED   = 6;

  // Fault latch states, Gray sequence along the usual path
  typedef enum logic [1:0] {
    FLT_IDLE  = 2'b00,
    FLT_MUTE  = 2'b01,
    FLT_WAIT  = 2'b11,
    FLT_ARMED = 2'b10
  } gdfe_flt_e;

endpackage

// ---- hw/gdfe_filt_if.sv ----
// Purpose: Carries one raw input and its deglitched copy
// Assumes: Raw side synchronous to core_clk
// Notes:   One instance per filtered pin
interface gdfe_filt_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ---- hw/gdfe_deglitch.sv ----
// Purpose: Discards pulses shorter than a fixed number of cycles
// Assumes: Input already synchronous to core_clk
// Notes:   Output follows only after the input held steady for the window
module gdfe_deglitch
  import gdfe_pkg::*;
#(
  parameter int unsigned CYC  = DEGLITCH_CYC,
  parameter logic        INIT = 1'b0
)(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  gdfe_filt_if.filt pin
);
  localparam int unsigned W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] stable_r;
  logic         clean_r;

  // Count how long the input differs from the held value
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stable_r <= '0;
      clean_r  <= INIT;
    end
    else if (pin.raw == clean_r)
      stable_r <= '0;
    else if (stable_r == LAST)
    begin
      stable_r <= '0;
      clean_r  <= pin.raw;
    end
    else
      stable_r <= stable_r + 1'b1;
  end

  assign pin.clean = clean_r;
endmodule

// ---- hw/gdfe_core.sv ----
// Purpose: Fault latch, enable, interlock and forced-on monitor of a gate driver
// Assumes: Supply-good, overcurrent and forced-on inputs are digital and synchronous
// Notes:   Open-drain pins are split into output value and output enable
module gdfe_core
  import gdfe_pkg::*;
#(
  parameter int unsigned FAULT_MUTE_NS     = 100000,
  parameter int unsigned RESET_FILTER_NS   = 1000,
  parameter int unsigned RESET_SHUTDOWN_NS = 2000
)(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Drive inputs
  input  wire logic              in_pos,
  input  wire logic              in_neg,
  input  wire logic              rst_en_n,
  // Digitized analog status
  input  wire logic              vcc_good,
  input  wire logic              vdd_good,
  input  wire logic              vee_good,
  input  wire logic              overcurrent_sense,
  input  wire logic              forced_on_input,
  input  wire gdfe_pkg::gdfe_level_t forced_on_level,
  // Output side
  output logic                   gate_output,
  output logic                   gate_hard_off,
  output logic                   gate_soft_off,
  output logic                   clamp_drive,
  output logic                   sense_pulldown,
  // Input side open-drain pins and monitor
  output logic                   fault_alarm_n_o,
  output logic                   fault_alarm_n_oe,
  output logic                   power_good_o,
  output logic                   power_good_oe,
  output logic                   forced_on_monitor_pwm,
  // Avalon-MM slave
  input  wire gdfe_pkg::gdfe_addr_t avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire gdfe_pkg::gdfe_data_t avs_writedata,
  output gdfe_pkg::gdfe_data_t   avs_readdata,
  output logic                   avs_waitrequest
);
  import gdfe_pkg::*;

  // Derived cycle counts; least times round up
  localparam int unsigned MUTE_CYC =
    (FAULT_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_CYC =
    (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHDN_CYC =
    (RESET_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam gdfe_cnt_t MUTE_RST = CNT_W'(MUTE_CYC);
  localparam gdfe_cnt_t FILT_RST = CNT_W'(FILT_CYC);
  localparam gdfe_cnt_t SHDN_RST = CNT_W'(SHDN_CYC);
  localparam logic [MON_W-1:0] MON_LAST = MON_W'(MON_PERIOD_CYC - 1);

  // High time of one monitor period for a given level
  function automatic logic [MON_W-1:0] mon_high(input gdfe_level_t lvl);
    int unsigned lo;
    int unsigned span;
    lo   = MON_PERIOD_CYC * MON_DUTY_MIN_PC / PCT_FULL;
    span = MON_PERIOD_CYC * (MON_DUTY_MAX_PC - MON_DUTY_MIN_PC);
    return MON_W'(lo + (span * lvl) / (PCT_FULL * ((1 << LEVEL_W) - 1)));
  endfunction

  // Saturating increment for duration counters
  function automatic gdfe_cnt_t sat_inc(input gdfe_cnt_t v);
    return (v == '1) ? v : v + 1'b1;
  endfunction

  // Deglitched drive inputs
  gdfe_filt_if pos_if ();
  gdfe_filt_if neg_if ();
  gdfe_filt_if en_if ();
  assign pos_if.raw = in_pos;
  assign neg_if.raw = in_neg;
  assign en_if.raw  = rst_en_n;

  gdfe_deglitch #(.CYC(DEGLITCH_CYC), .INIT(1'b0)) u_pos (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      (pos_if)
  );
  gdfe_deglitch #(.CYC(DEGLITCH_CYC), .INIT(1'b0)) u_neg (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      (neg_if)
  );
  // Starts low so an undriven pin keeps the driver disabled
  gdfe_deglitch #(.CYC(DEGLITCH_CYC), .INIT(1'b0)) u_en (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      (en_if)
  );

  logic      pos_f;
  logic      neg_f;
  logic      en_f;
  assign pos_f = pos_if.clean;
  assign neg_f = neg_if.clean;
  assign en_f  = en_if.clean;

  // Software-set durations
  gdfe_cnt_t mute_cyc_r;
  gdfe_cnt_t filt_cyc_r;
  gdfe_cnt_t shdn_cyc_r;

  // State
  gdfe_flt_e flt_r;
  gdfe_flt_e flt_nxt;
  gdfe_cnt_t mute_cnt_r;
  gdfe_cnt_t low_cnt_r;
  logic      en_d_r;
  logic      gate_r;
  logic      gate_nxt;
  logic      soft_r;
  logic      soft_nxt;
  logic      hard_r;
  logic      hard_nxt;
  logic      ack_r;
  logic      out_ok;
  logic      all_ok;
  logic      oc_hit;
  logic      en_rise;
  logic      fault_on;

  assign out_ok   = vdd_good & vee_good;
  assign all_ok   = out_ok & vcc_good;
  assign en_rise  = en_f & ~en_d_r;
  assign fault_on = (flt_r != FLT_IDLE);
  assign oc_hit   = overcurrent_sense & gate_r;

  // Edge history of the enable input
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      en_d_r <= 1'b0;
    else
      en_d_r <= en_f;
  end

  // How long the enable input has been low
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || en_f)
      low_cnt_r <= '0;
    else
      low_cnt_r <= sat_inc(low_cnt_r);
  end

  // Mute timer runs only right after the fault latches
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || flt_r != FLT_MUTE)
      mute_cnt_r <= '0;
    else
      mute_cnt_r <= sat_inc(mute_cnt_r);
  end

  // Fault latch sequencing
  always_comb
  begin
    flt_nxt = flt_r;
    unique case (flt_r)
      FLT_IDLE:
        if (oc_hit)
          flt_nxt = FLT_MUTE;
      FLT_MUTE:
        if (mute_cnt_r >= mute_cyc_r)
          flt_nxt = FLT_WAIT;
      FLT_WAIT:
        if (!en_f && low_cnt_r > filt_cyc_r)
          flt_nxt = FLT_ARMED;
      FLT_ARMED:
        if (en_rise || oc_hit)
          flt_nxt = oc_hit ? FLT_MUTE : FLT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flt_r <= FLT_IDLE;
    else
      flt_r <= flt_nxt;
  end

  // Output stage decision, highest priority first
  always_comb
  begin
    gate_nxt = 1'b0;
    soft_nxt = 1'b0;
    hard_nxt = 1'b1;
    if (!out_ok)
      hard_nxt = 1'b1;
    else if (forced_on_input)
    begin
      gate_nxt = 1'b1;
      hard_nxt = 1'b0;
    end
    else if (!vcc_good)
      hard_nxt = 1'b1;
    else if (fault_on || oc_hit)
    begin
      soft_nxt = 1'b1;
      hard_nxt = 1'b0;
    end
    else if (!en_f)
    begin
      soft_nxt = (low_cnt_r > shdn_cyc_r);
      hard_nxt = ~soft_nxt;
    end
    else if (neg_f)
      hard_nxt = 1'b1;
    else
    begin
      gate_nxt = pos_f;
      hard_nxt = ~pos_f;
    end
  end

  // Registered gate controls
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gate_r <= 1'b0;
      soft_r <= 1'b0;
      hard_r <= 1'b1;
    end
    else
    begin
      gate_r <= gate_nxt;
      soft_r <= soft_nxt;
      hard_r <= hard_nxt;
    end
  end

  assign gate_output    = gate_r;
  assign gate_soft_off  = soft_r;
  assign gate_hard_off  = hard_r;
  assign clamp_drive    = ~gate_r;
  assign sense_pulldown = ~gate_r;

  // Open-drain pins: enable high pulls the pin low
  assign fault_alarm_n_o  = 1'b0;
  assign fault_alarm_n_oe = fault_on & out_ok;
  assign power_good_o     = 1'b0;
  assign power_good_oe    = ~all_ok;

  // Forced-on level monitor, fixed period
  logic [MON_W-1:0] mon_cnt_r;
  logic [MON_W-1:0] mon_hi_r;
  logic             mon_pwm_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mon_cnt_r <= '0;
    else if (mon_cnt_r == MON_LAST)
      mon_cnt_r <= '0;
    else
      mon_cnt_r <= mon_cnt_r + 1'b1;
  end

  // Level sampled once per period so duty never tears mid-cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mon_hi_r <= mon_high('0);
    else if (mon_cnt_r == MON_LAST)
      mon_hi_r <= mon_high(forced_on_level);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mon_pwm_r <= 1'b0;
    else
      mon_pwm_r <= (mon_cnt_r < mon_hi_r);
  end

  assign forced_on_monitor_pwm = mon_pwm_r;

  // Avalon slave: one wait cycle, answer on the second edge
  logic bus_req;
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end

  // Duration registers written by software
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mute_cyc_r <= MUTE_RST;
      filt_cyc_r <= FILT_RST;
      shdn_cyc_r <= SHDN_RST;
    end
    else if (avs_write && !avs_waitrequest)
    begin
      unique case (avs_address)
        REG_MUTE_CYC: mute_cyc_r <= avs_writedata[CNT_W-1:0];
        REG_FILT_CYC: filt_cyc_r <= avs_writedata[CNT_W-1:0];
        REG_SHDN_CYC: shdn_cyc_r <= avs_writedata[CNT_W-1:0];
        default:      ;
      endcase
    end
  end

  // Read data captured on the waiting cycle, stands at the answer edge
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      avs_readdata <= '0;
    else if (avs_read && !ack_r)
    begin
      avs_readdata <= '0;
      unique case (avs_address)
        REG_STATUS:
        begin
          avs_readdata[ST_FAULT]    <= fault_on;
          avs_readdata[ST_ENABLED]  <= en_f;
          avs_readdata[ST_PGOOD]    <= all_ok;
          avs_readdata[ST_MUTE]     <= (flt_r == FLT_MUTE);
          avs_readdata[ST_GATE]     <= gate_r;
          avs_readdata[ST_SOFT_OFF] <= soft_r;
          avs_readdata[ST_FORCED]   <= forced_on_input;
        end
        REG_MUTE_CYC: avs_readdata[CNT_W-1:0] <= mute_cyc_r;
        REG_FILT_CYC: avs_readdata[CNT_W-1:0] <= filt_cyc_r;
        REG_SHDN_CYC: avs_readdata[CNT_W-1:0] <= shdn_cyc_r;
        default:      avs_readdata <= '0; // Unmapped reads zero
      endcase
    end
  end
endmodule

// ---- tb/gdfe_core_sva.sv ----
// Purpose: Port-level assertions for the gate driver fault logic
// Assumes: Mute count is never set below 8 cycles
// Notes:   Bound into every gdfe_core instance
module gdfe_core_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_neg,
  input wire logic rst_en_n,
  input wire logic vcc_good,
  input wire logic vdd_good,
  input wire logic vee_good,
  input wire logic overcurrent_sense,
  input wire logic forced_on_input,
  input wire logic gate_output,
  input wire logic gate_hard_off,
  input wire logic gate_soft_off,
  input wire logic clamp_drive,
  input wire logic fault_alarm_n_oe,
  input wire logic power_good_oe,
  input wire logic forced_on_monitor_pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] per_r;
  logic       pwm_r;
  logic       seen_r;
  wire        up     = forced_on_monitor_pwm && !pwm_r;
  wire        out_ok = vdd_good && vee_good;
  wire        all_ok = out_ok && vcc_good;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Cycles since the last monitor rise; first period is not judged
  always_ff @(posedge core_clk)
  begin
    pwm_r  <= sys_rst ? 1'b0 : forced_on_monitor_pwm;
    per_r  <= (sys_rst || up) ? 9'h000 : per_r + 9'h001;
    seen_r <= sys_rst ? 1'b0 : (seen_r || up);
  end
  a_oc_sets_alarm: assert property (gate_output && overcurrent_sense
    |=> fault_alarm_n_oe || !out_ok) else $error("alarm not raised");
  a_alarm_held: assert property (rst_en_n[*8] ##1 rst_en_n[*4] ##0 fault_alarm_n_oe
    |=> fault_alarm_n_oe || !out_ok) else $error("alarm dropped");
  a_fault_soft_off: assert property ($rose(fault_alarm_n_oe) && $past(gate_output)
    && !forced_on_input && vcc_good |-> !gate_output && gate_soft_off) else $error("no soft off");
  a_mute_holds: assert property ($rose(fault_alarm_n_oe) && $past(gate_output)
    |-> (fault_alarm_n_oe || !out_ok)[*8]) else $error("alarm cleared in mute");
  a_disable_off: assert property ((!rst_en_n && !forced_on_input && all_ok)[*8]
    |-> !gate_output && (gate_hard_off || gate_soft_off)) else $error("gate on while off");
  a_forced_gate: assert property ((forced_on_input && out_ok)[*3] |-> gate_output)
    else $error("forced on ignored");
  a_neg_interlock: assert property ((in_neg && !forced_on_input)[*8]
    |-> !gate_output && clamp_drive) else $error("interlock broken");
  a_out_supply_low: assert property ((!out_ok)[*2] |-> !gate_output && clamp_drive
    && !fault_alarm_n_oe) else $error("output supply loss missed");
  a_pgood_flag: assert property (power_good_oe == !all_ok)
    else $error("power good wrong");
  a_sense_gated: assert property (!gate_output && overcurrent_sense && out_ok
    && !fault_alarm_n_oe |=> !fault_alarm_n_oe) else $error("sense acted while off");
  a_mon_period: assert property (up && seen_r |-> per_r == 9'h137)
    else $error("monitor period wrong");
endmodule
bind gdfe_core gdfe_core_chk chk_u (.core_clk, .sys_rst, .in_neg, .rst_en_n, .vcc_good,
  .vdd_good, .vee_good, .overcurrent_sense, .forced_on_input, .gate_output, .gate_hard_off,
  .gate_soft_off, .clamp_drive, .fault_alarm_n_oe, .power_good_oe, .forced_on_monitor_pwm);

// ---- tb/gdfe_host.sv ----
// Purpose: Host controller model on the input side
// Assumes: Pull-ups on the alarm and power-good lines
// Notes:   Pins follow the commands one clock later
module gdfe_host (
  input  wire logic core_clk,
  input  wire logic cmd_pos,
  input  wire logic cmd_neg,
  input  wire logic cmd_en,
  output logic      in_pos = 1'b0,
  output logic      in_neg = 1'b0,
  output logic      rst_en_n = 1'b0,
  input  wire logic alarm_o,
  input  wire logic alarm_oe,
  input  wire logic good_o,
  input  wire logic good_oe,
  input  wire logic mon_pwm,
  output logic      fault_alarm_n,
  output logic      power_good,
  output logic [8:0] mon_high = 9'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] run_r = 9'h000;
  // Released lines float up to the pull-up level
  assign fault_alarm_n = alarm_oe ? alarm_o : 1'b1;
  assign power_good    = good_oe ? good_o : 1'b1;
  // Drive pins change only just after an edge
  always @(posedge core_clk)
  begin
    in_pos   <= cmd_pos;
    in_neg   <= cmd_neg;
    rst_en_n <= cmd_en;
  end
  // Length of the last high phase of the monitor
  always @(posedge core_clk)
  begin
    run_r <= mon_pwm ? run_r + 9'h001 : 9'h000;
    if (!mon_pwm && run_r != 9'h000)
      mon_high <= run_r;
  end
endmodule

// ---- tb/gdfe_core_bench.sv ----
// Purpose: Self-checking bench for gdfe_core
// Assumes: Short mute, filter and shutdown counts by parameter
// Notes:   Host model owns the drive pins and pull-ups
module gdfe_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import gdfe_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  sup = 3'h7;
  logic        oc = 1'b0;
  logic        fon = 1'b0;
  logic        pos = 1'b0;
  logic        neg = 1'b0;
  logic        en = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  gdfe_level_t lvl = 8'h00;
  gdfe_addr_t  adr = 4'h0;
  gdfe_data_t  wdat = 32'h0;
  gdfe_data_t  rdat;
  gdfe_data_t  q;
  logic        in_pos, in_neg, rst_en_n, gate, hoff, soff, clamp, spd;
  logic        a_o, a_oe, g_o, g_oe, pwm, wrq, flt_n, pgood;
  logic [8:0]  hi;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // Free-running core clock
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  gdfe_core #(.FAULT_MUTE_NS(160), .RESET_FILTER_NS(40), .RESET_SHUTDOWN_NS(80)) dut_u (
    .core_clk, .sys_rst, .in_pos, .in_neg, .rst_en_n, .vcc_good(sup[0]), .vdd_good(sup[1]),
    .vee_good(sup[2]), .overcurrent_sense(oc), .forced_on_input(fon), .forced_on_level(lvl),
    .gate_output(gate), .gate_hard_off(hoff), .gate_soft_off(soff), .clamp_drive(clamp),
    .sense_pulldown(spd), .fault_alarm_n_o(a_o), .fault_alarm_n_oe(a_oe), .power_good_o(g_o),
    .power_good_oe(g_oe), .forced_on_monitor_pwm(pwm), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wrq));
  gdfe_host host_u (.core_clk, .cmd_pos(pos), .cmd_neg(neg), .cmd_en(en), .in_pos, .in_neg,
    .rst_en_n, .alarm_o(a_o), .alarm_oe(a_oe), .good_o(g_o), .good_oe(g_oe), .mon_pwm(pwm),
    .fault_alarm_n(flt_n), .power_good(pgood), .mon_high(hi));
  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic a, input logic e);
    num_checks++;
    if (a !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, a, e);
    end
  endtask
  task automatic chkw(input gdfe_data_t a, input gdfe_data_t e);
    num_checks++;
    if (a !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, a, e);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input gdfe_addr_t a, input gdfe_data_t d);
    @(posedge core_clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    @(posedge core_clk);
    while (wrq !== 1'b0)
      @(posedge core_clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Monitor high time: 5% of the period plus a linear share of the 90% span
  function automatic gdfe_data_t mon_exp(input int l);
    return gdfe_data_t'(MON_PERIOD_CYC * MON_DUTY_MIN_PC / PCT_FULL
      + MON_PERIOD_CYC * (MON_DUTY_MAX_PC - MON_DUTY_MIN_PC) * l / (PCT_FULL * 255));
  endfunction
  // Watchdog well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial
  begin
    int i;
    int m;
    m = $urandom(23);
    wt(10);
    sys_rst <= 1'b0;
    bus(1'b0, REG_MUTE_CYC, 32'h0);
    chkw(q, 32'h14);
    bus(1'b1, REG_MUTE_CYC, 32'hfff0001e);
    bus(1'b0, REG_MUTE_CYC, 32'h0);
    chkw(q, 32'h1e);
    bus(1'b1, REG_STATUS, 32'hffffffff);
    bus(1'b0, 4'h2, 32'h0);
    chkw(q, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[ST_FAULT], 1'b0);
    chk(q[ST_PGOOD], 1'b1);
    chk(q[ST_ENABLED], 1'b0);
    bus(1'b0, REG_FILT_CYC, 32'h0);
    chkw(q, 32'h5);
    bus(1'b0, REG_SHDN_CYC, 32'h0);
    chkw(q, 32'ha);
    pos <= 1'b1;
    wt(12);
    chk(gate, 1'b0);
    en <= 1'b1;
    wt(12);
    chk(gate, 1'b1);
    // Random drive pairs, interlock holds
    for (i = 0; i < 24; i++)
    begin
      pos <= 1'($urandom);
      neg <= 1'($urandom);
      wt(12);
      chk(gate, pos & ~neg);
      chk(clamp, ~(pos & ~neg));
      chk(spd, ~(pos & ~neg));
    end
    pos <= 1'b0;
    neg <= 1'b0;
    wt(12);
    pos <= 1'b1;
    oc  <= 1'b1;
    wt(3);
    pos <= 1'b0;
    oc  <= 1'b0;
    wt(12);
    chk(gate, 1'b0);
    chk(flt_n, 1'b1);
    pos <= 1'b1;
    wt(12);
    oc <= 1'b1;
    wt(1);
    oc <= 1'b0;
    wt(1);
    chk(flt_n, 1'b0);
    chk(soff, 1'b1);
    chk(gate, 1'b0);
    // Reset inside mute, then too short, then valid
    en <= 1'b0;
    wt(12);
    en <= 1'b1;
    wt(12);
    chk(flt_n, 1'b0);
    wt(10);
    en <= 1'b0;
    wt(3);
    en <= 1'b1;
    wt(12);
    chk(flt_n, 1'b0);
    en <= 1'b0;
    wt(12);
    chk(flt_n, 1'b0);
    en <= 1'b1;
    wt(12);
    chk(flt_n, 1'b1);
    chk(gate, 1'b1);
    en <= 1'b0;
    wt(10);
    chk(hoff, 1'b1);
    chk(soff, 1'b0);
    wt(20);
    chk(soff, 1'b1);
    fon <= 1'b1;
    wt(4);
    chk(gate, 1'b1);
    for (i = 0; i < 3; i++)
    begin
      m = (i == 0) ? 0 : (i == 1) ? 255 : int'($urandom % 256);
      lvl <= 8'(m);
      wt(700);
      chkw(32'(hi), mon_exp(m));
    end
    fon <= 1'b0;
    en  <= 1'b1;
    wt(12);
    // Drop each supply in turn, then recover
    for (i = 0; i < 3; i++)
    begin
      sup <= 3'h7 ^ (3'h1 << i);
      wt(4);
      chk(gate, 1'b0);
      chk(pgood, 1'b0);
      chk(clamp, 1'b1);
      sup <= 3'h7;
      wt(12);
      chk(gate, 1'b1);
      chk(pgood, 1'b1);
    end
    report_and_stop();
  end
endmodule
